// File: rtl/cdio_pkg.sv
// package for the command driven digital i/o port
// assumes one 10 MHz clock; commands arrive already decoded from an interpreter
package cdio_pkg;
   localparam int unsigned CDIO_CLK_HZ = 10000000;
   localparam int unsigned CDIO_MS_PER_S = 1000;
   localparam int unsigned CDIO_CYC_PER_MS = CDIO_CLK_HZ / CDIO_MS_PER_S;
   localparam int unsigned CDIO_BASE_OUTS = 8;
   localparam int unsigned CDIO_EXTRA_OUTS = 8;
   localparam int unsigned CDIO_WORD_W = 16;
   localparam int unsigned CDIO_EXT_POINTS = 32;
   localparam int unsigned CDIO_GROUP_W = 8;
   localparam int unsigned CDIO_NGROUPS = CDIO_EXT_POINTS / CDIO_GROUP_W;
   localparam int unsigned CDIO_NINPUTS = 48;
   localparam int unsigned CDIO_EXT_FIRST = 17;
   localparam int unsigned CDIO_IDX_W = 6;
   localparam int unsigned CDIO_MS_W = 16;
   localparam logic [15:0] CDIO_OUT_RESET = 16'h0000;
   localparam logic [3:0] CDIO_DIR_RESET = 4'h0;

   typedef enum logic [2:0] {
      CDIO_SET_BIT,
      CDIO_CLEAR_BIT,
      CDIO_COND_OUT,
      CDIO_WORD_WRITE,
      CDIO_DIR_CONFIG,
      CDIO_BULK_READ,
      CDIO_WAIT_INPUT,
      CDIO_DELAY_WAIT
   } cdio_op_e;

   // one decoded command; index is signed for the wait-on-input level choice
   typedef struct packed {
      cdio_op_e op;
      logic signed [CDIO_IDX_W:0] index;
      logic [31:0] operand;
   } cdio_cmd_s;

   typedef struct packed {
      logic [CDIO_WORD_W-1:0] outputs;
      logic [CDIO_EXT_POINTS-1:0] ext_out;
      logic [CDIO_EXT_POINTS-1:0] ext_oe;
   } cdio_pins_s;
endpackage : cdio_pkg

// File: rtl/cdio_port.sv
// command driven digital i/o port: dedicated outputs, optional extra outputs,
// and 32 extended points configurable in groups of eight
// assumes inputs synchronous to clk and one command at a time under valid/ready
//
// What this block does
// - eight dedicated outputs plus 32 configurable points
// - larger variants add eight more outputs
// - set or clear one output, others unchanged
// - conditional output on when operand nonzero
// - word write loads sixteen outputs, bit0 output1
// - word bit one means on, zero off
// - word write replaces whole port, six gives 2,3
// - single input query returns level, index 1-48
// - bulk read returns all inputs together
// - wait stalls until input high, negated low
// - delay waits counted in milliseconds
// - direction chosen per group of eight, 17-48
`timescale 1ns/100ps
`default_nettype none
module cdio_port
   import cdio_pkg::*;
#(
   parameter bit HAS_EXTRA_OUTS = 1'b1,
   parameter int unsigned CYC_PER_MS = CDIO_CYC_PER_MS
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire cdio_pkg::cdio_cmd_s cmd,
   // single input query
   input wire logic [CDIO_IDX_W-1:0] query_index,
   output logic query_level,
   // answers
   output logic done,
   output logic index_error,
   output logic [CDIO_NINPUTS-1:0] bulk_data,
   // field pins
   input wire logic [CDIO_NGROUPS*CDIO_GROUP_W+CDIO_EXT_FIRST-1-1:0] in_pins,
   output cdio_pkg::cdio_pins_s pins,
   output logic [CDIO_NGROUPS-1:0] group_is_output
);
   import cdio_pkg::*;

   initial
   begin
      if (CYC_PER_MS < 1)
         $error("CYC_PER_MS must be at least one");
   end

   localparam int unsigned NOUT = HAS_EXTRA_OUTS ? CDIO_WORD_W : CDIO_BASE_OUTS;
   localparam logic [CDIO_WORD_W-1:0] OUT_MASK = NOUT == CDIO_WORD_W ? 16'hFFFF : 16'h00FF;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_IN, ST_DELAY} cdio_state_e;

   cdio_state_e state_q, state_d;
   logic [CDIO_WORD_W-1:0] out_q, out_d;
   logic [CDIO_EXT_POINTS-1:0] ext_q, ext_d;
   logic [CDIO_NGROUPS-1:0] dir_q, dir_d;
   logic [CDIO_NINPUTS-1:0] bulk_q, bulk_d;
   logic [CDIO_MS_W-1:0] ms_q, ms_d;
   logic [31:0] cyc_q, cyc_d;
   logic [CDIO_IDX_W-1:0] wait_idx_q, wait_idx_d;
   logic wait_level_q, wait_level_d;
   logic done_q, done_d;
   logic err_q, err_d;
   logic [CDIO_NINPUTS-1:0] in_view;

   // level of point n (1-based); 0 for out-of-range
   function automatic logic pick(input logic [CDIO_NINPUTS-1:0] v,
                                 input logic [CDIO_IDX_W-1:0] n);
      logic r;
      r = 1'b0;
      if (n >= 1 && n <= CDIO_NINPUTS)
         r = v[n-1];
      return r;
   endfunction : pick

   function automatic logic [CDIO_IDX_W-1:0] mag(input logic signed [CDIO_IDX_W:0] i);
      logic signed [CDIO_IDX_W:0] a;
      a = i < 0 ? -i : i;
      return a[CDIO_IDX_W-1:0];
   endfunction : mag

   // output points read back their driven value, input groups the pins
   always_comb
   begin
      in_view = {CDIO_NINPUTS{1'b0}};
      in_view[CDIO_EXT_FIRST-2:0] = in_pins[CDIO_EXT_FIRST-2:0];
      for (int g = 0; g < CDIO_NGROUPS; g++)
      begin
         for (int b = 0; b < CDIO_GROUP_W; b++)
         begin
            in_view[CDIO_EXT_FIRST-1+g*CDIO_GROUP_W+b] = dir_q[g] ?
               ext_q[g*CDIO_GROUP_W+b] : in_pins[CDIO_EXT_FIRST-1+g*CDIO_GROUP_W+b];
         end
      end
   end

   always_comb
   begin
      logic [CDIO_IDX_W-1:0] n;
      logic bit_ok;
      n = mag(cmd.index);
      bit_ok = (n >= 1) && (n <= NOUT);
      state_d = state_q;
      out_d = out_q;
      ext_d = ext_q;
      dir_d = dir_q;
      bulk_d = bulk_q;
      ms_d = ms_q;
      cyc_d = cyc_q;
      wait_idx_d = wait_idx_q;
      wait_level_d = wait_level_q;
      done_d = 1'b0;
      err_d = err_q;
      unique case (state_q)
         ST_IDLE:
         begin
            if (cmd_valid)
            begin
               err_d = 1'b0;
               unique case (cmd.op)
                  CDIO_SET_BIT, CDIO_CLEAR_BIT, CDIO_COND_OUT:
                  begin
                     done_d = 1'b1;
                     if (bit_ok)
                     begin
                        if (cmd.op == CDIO_SET_BIT)
                           out_d[n-1] = 1'b1;
                        else if (cmd.op == CDIO_CLEAR_BIT)
                           out_d[n-1] = 1'b0;
                        else
                           out_d[n-1] = cmd.operand != 32'h0000_0000;
                     end
                     else if (n >= CDIO_EXT_FIRST && n <= CDIO_NINPUTS
                              && dir_q[(n-CDIO_EXT_FIRST)/CDIO_GROUP_W])
                     begin
                        if (cmd.op == CDIO_SET_BIT)
                           ext_d[n-CDIO_EXT_FIRST] = 1'b1;
                        else if (cmd.op == CDIO_CLEAR_BIT)
                           ext_d[n-CDIO_EXT_FIRST] = 1'b0;
                        else
                           ext_d[n-CDIO_EXT_FIRST] = cmd.operand != 32'h0000_0000;
                     end
                     else
                        err_d = 1'b1;
                  end
                  CDIO_WORD_WRITE:
                  begin
                     // whole replace, no merge; unbuilt outputs stay off
                     out_d = cmd.operand[CDIO_WORD_W-1:0] & OUT_MASK;
                     done_d = 1'b1;
                  end
                  CDIO_DIR_CONFIG:
                  begin
                     dir_d = cmd.operand[CDIO_NGROUPS-1:0];
                     done_d = 1'b1;
                  end
                  CDIO_BULK_READ:
                  begin
                     bulk_d = in_view;
                     done_d = 1'b1;
                  end
                  CDIO_WAIT_INPUT:
                  begin
                     if (n >= 1 && n <= CDIO_NINPUTS)
                     begin
                        wait_idx_d = n;
                        wait_level_d = cmd.index > 0;
                        state_d = ST_WAIT_IN;
                     end
                     else
                     begin
                        err_d = 1'b1;
                        done_d = 1'b1;
                     end
                  end
                  CDIO_DELAY_WAIT:
                  begin
                     ms_d = cmd.operand[CDIO_MS_W-1:0];
                     cyc_d = 32'h0000_0000;
                     if (cmd.operand[CDIO_MS_W-1:0] == 16'h0000)
                        done_d = 1'b1;
                     else
                        state_d = ST_DELAY;
                  end
               endcase
            end
         end
         ST_WAIT_IN:
         begin
            if (pick(in_view, wait_idx_q) == wait_level_q)
            begin
               done_d = 1'b1;
               state_d = ST_IDLE;
            end
         end
         ST_DELAY:
         begin
            // cycle counter wraps each millisecond, then the ms count steps down
            if (cyc_q == 32'(CYC_PER_MS - 1))
            begin
               cyc_d = 32'h0000_0000;
               ms_d = ms_q - 16'h0001;
               if (ms_q == 16'h0001)
               begin
                  done_d = 1'b1;
                  state_d = ST_IDLE;
               end
            end
            else
               cyc_d = cyc_q + 32'h0000_0001;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         out_q <= CDIO_OUT_RESET;
         ext_q <= 32'h0000_0000;
         dir_q <= CDIO_DIR_RESET;
         bulk_q <= 48'h0000_0000_0000;
         ms_q <= 16'h0000;
         cyc_q <= 32'h0000_0000;
         wait_idx_q <= 6'h00;
         wait_level_q <= 1'b0;
         done_q <= 1'b0;
         err_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         out_q <= out_d;
         ext_q <= ext_d;
         dir_q <= dir_d;
         bulk_q <= bulk_d;
         ms_q <= ms_d;
         cyc_q <= cyc_d;
         wait_idx_q <= wait_idx_d;
         wait_level_q <= wait_level_d;
         done_q <= done_d;
         err_q <= err_d;
      end
   end

   always_comb
   begin
      pins.outputs = out_q;
      pins.ext_out = ext_q;
      for (int g = 0; g < CDIO_NGROUPS; g++)
         pins.ext_oe[g*CDIO_GROUP_W +: CDIO_GROUP_W] = {CDIO_GROUP_W{dir_q[g]}};
   end

   assign cmd_ready = state_q == ST_IDLE;
   // query is combinational so software sees the present level
   assign query_level = pick(in_view, query_index);
   assign done = done_q;
   assign index_error = err_q;
   assign bulk_data = bulk_q;
   assign group_is_output = dir_q;
endmodule : cdio_port
`default_nettype wire

// File: test/cdio_port_properties.sv
// checker for the digital i/o port, watching only its ports
// assumes the bench sets CYC_PER_MS to 2 so one millisecond is two cycles
`timescale 1ns/100ps
`default_nettype none
module cdio_port_properties
   import cdio_pkg::*;
#(
   parameter bit HAS_EXTRA_OUTS = 1'b1,
   parameter int unsigned CYC_PER_MS = CDIO_CYC_PER_MS
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // command side
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire cdio_pkg::cdio_cmd_s cmd,
   input wire logic [CDIO_IDX_W-1:0] query_index,
   input wire logic query_level,
   input wire logic done,
   input wire logic index_error,
   input wire logic [CDIO_NINPUTS-1:0] bulk_data,
   // field side
   input wire logic [47:0] in_pins,
   input wire cdio_pkg::cdio_pins_s pins,
   input wire logic [CDIO_NGROUPS-1:0] group_is_output
);
   localparam int OMAX = HAS_EXTRA_OUTS ? 16 : 8;
   logic take;
   logic [5:0] ix;
   assign take = cmd_valid && cmd_ready;
   assign ix = cmd.index[5:0];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_word_load: assert property (take && cmd.op == CDIO_WORD_WRITE |=>
      pins.outputs == $past(cmd.operand[15:0])) else $error("word write wrong");
   a_set_one: assert property (take && cmd.op == CDIO_SET_BIT && cmd.index > 0 &&
      cmd.index <= OMAX |=> pins.outputs == ($past(pins.outputs) | 16'h0001 << ($past(ix) - 1)))
      else $error("set bit wrong");
   a_clear_one: assert property (take && cmd.op == CDIO_CLEAR_BIT && cmd.index > 0 &&
      cmd.index <= OMAX |=> pins.outputs == ($past(pins.outputs) & ~(16'h0001 << ($past(ix) - 1))))
      else $error("clear bit wrong");
   a_cond_out: assert property (take && cmd.op == CDIO_COND_OUT && cmd.index > 0 &&
      cmd.index <= OMAX |=> pins.outputs[$past(ix) - 1] == ($past(cmd.operand) != 0))
      else $error("conditional output wrong");
   a_outputs_hold: assert property (!(take && cmd.op inside {CDIO_SET_BIT, CDIO_CLEAR_BIT,
      CDIO_COND_OUT, CDIO_WORD_WRITE}) |=> $stable(pins.outputs)) else $error("outputs moved");
   a_query_level: assert property (query_index >= 1 && query_index <= 48 |->
      query_level == in_pins[query_index - 1]) else $error("query level wrong");
   a_bulk_snap: assert property (take && cmd.op == CDIO_BULK_READ |=>
      bulk_data == $past(in_pins)) else $error("bulk read wrong");
   a_wait_stall: assert property (take && cmd.op == CDIO_WAIT_INPUT &&
      cmd.index inside {[-48:-1], [1:48]} |=> !cmd_ready) else $error("wait did not stall");
   // done registers on the edge that ends the second cycle, so it is seen one edge later
   a_delay_ms: assert property (take && cmd.op == CDIO_DELAY_WAIT && CYC_PER_MS == 2 &&
      cmd.operand[15:0] == 16'h0001 |=> !done ##1 !done ##1 done) else $error("delay length wrong");
   a_dir_load: assert property (take && cmd.op == CDIO_DIR_CONFIG |=>
      group_is_output == $past(cmd.operand[3:0])) else $error("direction wrong");
   a_group_oe: assert property (pins.ext_oe == {{8{group_is_output[3]}},
      {8{group_is_output[2]}}, {8{group_is_output[1]}}, {8{group_is_output[0]}}})
      else $error("enables not per group");
   c_word: cover property (take && cmd.op == CDIO_WORD_WRITE);
   c_wait: cover property (take && cmd.op == CDIO_WAIT_INPUT ##[1:20] done);
   c_error: cover property (done && index_error);
endmodule : cdio_port_properties
bind cdio_port cdio_port_properties #(.HAS_EXTRA_OUTS(HAS_EXTRA_OUTS), .CYC_PER_MS(CYC_PER_MS))
   u_props (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .cmd(cmd), .query_index(query_index), .query_level(query_level), .done(done),
   .index_error(index_error), .bulk_data(bulk_data), .in_pins(in_pins), .pins(pins),
   .group_is_output(group_is_output));
`default_nettype wire

// File: test/cdio_field_model.sv
// field side model: switches on inputs, driven points read back their drive
// assumes the bench sets the switch levels
`timescale 1ns/100ps
`default_nettype none
module cdio_field_model
   import cdio_pkg::*;
(
   // bench side
   input wire logic [47:0] sw,
   // device pins
   input wire cdio_pkg::cdio_pins_s pins,
   output logic [47:0] in_pins
);
   // a point in an output group shows the device drive, not the switch
   assign in_pins = {(pins.ext_oe & pins.ext_out) | (~pins.ext_oe & sw[47:16]), sw[15:0]};
endmodule : cdio_field_model
`default_nettype wire

// File: test/test_command_driven_digital_io_port.sv
// bench for the digital i/o port with a field model
// assumes CYC_PER_MS of 2; expectations kept in a queue, popped on done
`timescale 1ns/100ps
`default_nettype none
module test_command_driven_digital_io_port;
   import cdio_pkg::*;
   logic clk, rst_n, cmd_valid, cmd_ready, query_level, done, index_error;
   cdio_cmd_s cmd;
   logic [5:0] query_index;
   logic [47:0] bulk_data, in_pins, sw;
   cdio_pins_s pins;
   logic [3:0] group_is_output, grp;
   logic [16:0] exp_q[$];
   logic [15:0] mo;
   logic [31:0] seed, r, ext, oe;
   int failures, n_checks, cyc, q;
   cdio_port #(.CYC_PER_MS(2)) dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd(cmd), .query_index(query_index), .query_level(query_level),
      .done(done), .index_error(index_error), .bulk_data(bulk_data), .in_pins(in_pins),
      .pins(pins), .group_is_output(group_is_output));
   cdio_field_model field (.sw(sw), .pins(pins), .in_pins(in_pins));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task chk(input logic [47:0] got, input logic [47:0] want);
      n_checks++;
      if (got !== want)
      begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, want);
      end
   endtask : chk
   task results;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   // bench keeps its own image of outputs, drives and groups
   task send(input cdio_op_e op, input logic signed [6:0] idx, input logic [31:0] opd);
      int m;
      logic ok, v;
      m = idx < 0 ? -idx : idx;
      v = op == CDIO_SET_BIT || (op == CDIO_COND_OUT && opd != 0);
      ok = op inside {CDIO_WORD_WRITE, CDIO_DIR_CONFIG, CDIO_BULK_READ, CDIO_DELAY_WAIT}
         || (m >= 1 && (m <= 16 || (m <= 48 && (op == CDIO_WAIT_INPUT || grp[(m-17)/8]))));
      if (op == CDIO_WORD_WRITE) mo = opd[15:0];
      if (ok && op <= CDIO_COND_OUT && m <= 16) mo[m-1] = v;
      if (ok && op <= CDIO_COND_OUT && m > 16) ext[m-17] = v;
      if (op == CDIO_DIR_CONFIG) grp = opd[3:0];
      exp_q.push_back({!ok, mo});
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{op, idx, opd};
      // ready is looked at mid-cycle, away from the edge that moves it
      do @(negedge clk); while (cmd_ready !== 1'b1);
      @(posedge clk);
      cmd_valid <= 1'b0;
   endtask : send
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // outputs are sampled mid-cycle where they are settled
   always @(negedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         results();
      end
      if (done === 1'b1 && exp_q.size() == 0) chk(1, 0);
      else if (done === 1'b1) chk({index_error, pins.outputs}, exp_q.pop_front());
   end
   initial
   begin
      {rst_n, cmd_valid, cmd, query_index, sw, mo, grp, ext} = '0;
      seed = 32'h96782577;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      send(CDIO_WORD_WRITE, 0, 32'hFFFF);
      send(CDIO_WORD_WRITE, 0, 6);
      for (int k = 1; k <= 16; k++) send(k[0] ? CDIO_SET_BIT : CDIO_CLEAR_BIT, 7'(k), 0);
      repeat (40)
      begin
         r = rnd();
         send(cdio_op_e'({1'b0, r[1:0]}), 7'(r[9:4] % 20), r[31] ? r : 0);
      end
      $display("output commands done");
      send(CDIO_DIR_CONFIG, 0, 5);
      send(CDIO_SET_BIT, 7'sd17, 0);
      send(CDIO_SET_BIT, 7'sd25, 0);
      repeat (30)
      begin
         r = rnd();
         sw <= {r[15:0], r};
         query_index <= 6'(r[7:2] % 48 + 1);
         @(negedge clk);
         q = query_index;
         chk(query_level, q > 16 && grp[(q-17)/8] ? ext[q-17] : sw[q-1]);
         @(posedge clk);
      end
      send(CDIO_BULK_READ, 0, 0);
      @(negedge clk);
      oe = {{8{grp[3]}}, {8{grp[2]}}, {8{grp[1]}}, {8{grp[0]}}};
      chk(bulk_data, {(ext & oe) | (sw[47:16] & ~oe), sw[15:0]});
      chk(group_is_output, grp);
      $display("input queries done");
      sw <= 48'h20;
      send(CDIO_WAIT_INPUT, -7'sd6, 0);
      repeat (4) @(posedge clk);
      chk(cmd_ready, 0);
      sw <= 48'h0;
      send(CDIO_WAIT_INPUT, 7'sd7, 0);
      repeat (4) @(posedge clk);
      chk(cmd_ready, 0);
      sw <= 48'h40;
      send(CDIO_DELAY_WAIT, 0, 1);
      send(CDIO_DELAY_WAIT, 0, 3);
      send(CDIO_WORD_WRITE, 0, 0);
      repeat (5) @(posedge clk);
      chk(exp_q.size(), 0);
      $display("wait and delay done");
      results();
   end
endmodule : test_command_driven_digital_io_port
`default_nettype wire
